// *** pkg/timer_event_pkg.sv ***
// constants and types shared by the timer/event counter set
package timer_event_pkg;

    // ==========================================================
    // register select codes on the sfr select bus
    localparam logic [2:0] SEL_C0_LOW   = 3'h0;
    localparam logic [2:0] SEL_C0_HIGH  = 3'h1;
    localparam logic [2:0] SEL_C1_LOW   = 3'h2;
    localparam logic [2:0] SEL_C1_HIGH  = 3'h3;
    localparam logic [2:0] SEL_C2_VALUE = 3'h4;
    localparam logic [2:0] SEL_C0_CTRL  = 3'h5;
    localparam logic [2:0] SEL_C1_CTRL  = 3'h6;
    localparam logic [2:0] SEL_C2_CTRL  = 3'h7;

    // ==========================================================
    // control register fields
    localparam int MODE_HI_POS = 7;
    localparam int MODE_LO_POS = 6;
    localparam int RUN_POS     = 4;
    localparam int EDGE_POS    = 3;
    localparam int PSC_HI_POS  = 2;
    localparam int PSC_LO_POS  = 0;

    localparam logic [7:0] CTRL_RESET     = 8'h00;
    // bit 5 unimplemented; unit 1 has no prescaler field
    localparam logic [7:0] CTRL_MASK_PSC  = 8'hdf;
    localparam logic [7:0] CTRL_MASK_NPSC = 8'hd8;

    // ==========================================================
    // units and widths
    localparam int NUM_UNITS   = 3;
    localparam int WIDE_BITS   = 16;
    localparam int NARROW_BITS = 8;
    localparam int PSC_BITS    = 7;
    localparam logic [PSC_BITS-1:0] PSC_RESET = 7'h00;
    localparam logic [7:0] BYTE_RESET = 8'h00;

    typedef enum logic [1:0] {
        MODE_IDLE  = 2'b00,
        MODE_EVENT = 2'b01,
        MODE_TIMER = 2'b10,
        MODE_PULSE = 2'b11
    } mode_t;

endpackage : timer_event_pkg

// *** hw/pin_sync.sv ***
// three-stage pin synchroniser with agreement filter and edge pulses
`timescale 1ns/100ps
`default_nettype none
module pin_sync
    import timer_event_pkg::*;
(
    input  wire logic i_clock,
    input  wire logic i_rstn,
    input  wire logic i_pin,
    output logic      o_level,
    output logic      o_rise,
    output logic      o_fall
);
    logic       stage1_reg;
    logic       stage2_reg;
    logic       stage3_reg;
    logic       level_reg;
    logic       rise_reg;
    logic       fall_reg;
    logic [2:0] warm_reg;

    // ==========================================================
    // synchroniser chain
    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            stage1_reg <= 1'b0;
            stage2_reg <= 1'b0;
            stage3_reg <= 1'b0;
        end else begin
            stage1_reg <= i_pin;
            stage2_reg <= stage1_reg;
            stage3_reg <= stage2_reg;
        end
    end

    // ==========================================================
    // accepted level moves only when stages two and three agree;
    // just after reset the level adopts the pin without an edge, so a
    // pin idling high gives no false rise
    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            level_reg <= 1'b0;
            rise_reg  <= 1'b0;
            fall_reg  <= 1'b0;
            warm_reg  <= 3'h0;
        end else begin
            rise_reg <= 1'b0;
            fall_reg <= 1'b0;
            warm_reg <= {warm_reg[1:0], 1'b1};
            if (!warm_reg[2]) begin
                level_reg <= stage2_reg;
            end else if ((stage2_reg == stage3_reg) && (stage3_reg != level_reg)) begin
                level_reg <= stage3_reg;
                rise_reg  <= stage3_reg;
                fall_reg  <= ~stage3_reg;
            end
        end
    end

    assign o_level = level_reg;
    assign o_rise  = rise_reg;
    assign o_fall  = fall_reg;
endmodule : pin_sync
`default_nettype wire

// *** hw/count_unit.sv ***
// one up-counting unit with preload, overflow reload and pulse measurement
`timescale 1ns/100ps
`default_nettype none
module count_unit
    import timer_event_pkg::*;
#(
    parameter int W = WIDE_BITS
) (
    input  wire logic         i_clock,
    input  wire logic         i_rstn,
    input  wire logic         i_tick,
    input  wire logic         i_pin_rise,
    input  wire logic         i_pin_fall,
    input  wire mode_t        i_mode,
    input  wire logic         i_run,
    input  wire logic         i_edge,
    input  wire logic         i_load,
    input  wire logic [W-1:0] i_load_value,
    output logic      [W-1:0] o_count,
    output logic              o_overflow,
    output logic              o_measure_done
);
    logic [W-1:0] count_reg;
    logic [W-1:0] preload_reg;
    logic         armed_reg;
    logic         overflow_reg;
    logic         done_reg;
    logic         advance;
    logic         start_edge;
    logic         stop_edge;

    // edge bit high: events on falling; measurement starts rising
    assign start_edge = i_edge ? i_pin_rise : i_pin_fall;
    assign stop_edge  = i_edge ? i_pin_fall : i_pin_rise;

    // ==========================================================
    // count source per mode
    always_comb begin
        advance = 1'b0;
        case (i_mode)
            MODE_TIMER: advance = i_run & i_tick;
            MODE_EVENT: advance = i_run & (i_edge ? i_pin_fall : i_pin_rise);
            MODE_PULSE: advance = i_run & armed_reg & i_tick;
            default:    advance = 1'b0;
        endcase
    end

    // ==========================================================
    // pulse measurement window
    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            armed_reg <= 1'b0;
            done_reg  <= 1'b0;
        end else begin
            done_reg <= 1'b0;
            if (!i_run || (i_mode != MODE_PULSE)) begin
                armed_reg <= 1'b0;
            end else if (!armed_reg && start_edge) begin
                armed_reg <= 1'b1;
            end else if (armed_reg && stop_edge) begin
                armed_reg <= 1'b0;
                done_reg  <= 1'b1;
            end
        end
    end

    // ==========================================================
    // preload holds no reset value; software must clear it
    always_ff @(posedge i_clock) begin
        if (i_load) begin
            preload_reg <= i_load_value;
        end
    end

    // ==========================================================
    // live count
    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            count_reg    <= '0;
            overflow_reg <= 1'b0;
        end else begin
            overflow_reg <= 1'b0;
            if (i_load && !i_run) begin
                count_reg <= i_load_value;
            end else if (advance) begin
                if (&count_reg) begin
                    // a preload written while running lands only here
                    count_reg    <= preload_reg;
                    overflow_reg <= 1'b1;
                end else begin
                    count_reg <= count_reg + 1'b1;
                end
            end
        end
    end

    assign o_count        = count_reg;
    assign o_overflow     = overflow_reg;
    assign o_measure_done = done_reg;
endmodule : count_unit
`default_nettype wire

// *** hw/timer_event_counter_set.sv ***
// three timer/event counters behind the cpu special function registers
//
// What this block does
// - two sixteen-bit and one eight-bit up counter
// - each unit does timing, event counting or pulse width measurement
// - timer and pulse width modes count the system clock
// - event mode adds one per selected pin edge
// - count runs to all ones, then overflows and raises an interrupt
// - after overflow the preload value is reloaded and counting goes on
// - preload written while stopped also lands in the count at once
// - preload written while running waits for the next overflow
// - preload has no reset value; software clears it
// - low byte write goes to the low byte buffer only
// - high byte write loads high byte and moves buffer into low byte
// - high byte read latches live low byte into the buffer
// - low byte read returns the buffer, not the live byte
// - control bits seven and six select the mode
// - control bit four runs or halts the unit
// - control bits two to zero set prescaler of units zero and two
// - prescaler ignored when counting external pin edges
// - control bit three picks the active pin edge
`timescale 1ns/100ps
`default_nettype none
module timer_event_counter_set
    import timer_event_pkg::*;
(
    input  wire logic                 i_clock,
    input  wire logic                 i_rstn,
    input  wire logic [2:0]           i_sfr_sel,
    input  wire logic                 i_sfr_wr,
    input  wire logic                 i_sfr_rd,
    input  wire logic [7:0]           i_sfr_wdata,
    output logic      [7:0]           o_sfr_rdata,
    input  wire logic [NUM_UNITS-1:0] i_event_pin,
    output logic      [NUM_UNITS-1:0] o_overflow_irq
);
    // ==========================================================
    // declarations
    logic [7:0]          ctrl_reg [NUM_UNITS];
    logic [7:0]          low_buf0_reg;
    logic [7:0]          low_buf1_reg;
    logic [7:0]          rdata_reg;
    logic [PSC_BITS-1:0] psc_cnt_reg;

    logic [WIDE_BITS-1:0] count_val  [NUM_UNITS];
    logic [WIDE_BITS-1:0] load_value [NUM_UNITS];
    logic [NUM_UNITS-1:0] load_en;
    logic [NUM_UNITS-1:0] unit_tick;
    logic [NUM_UNITS-1:0] pin_rise;
    logic [NUM_UNITS-1:0] pin_fall;
    logic [NUM_UNITS-1:0] measure_done;
    logic [NUM_UNITS-1:0] overflow;

    logic wr_c0_low;
    logic wr_c0_high;
    logic wr_c1_low;
    logic wr_c1_high;
    logic wr_c2_value;
    logic rd_c0_high;
    logic rd_c1_high;

    // ==========================================================
    // bus decode
    assign wr_c0_low   = i_sfr_wr && (i_sfr_sel == SEL_C0_LOW);
    assign wr_c0_high  = i_sfr_wr && (i_sfr_sel == SEL_C0_HIGH);
    assign wr_c1_low   = i_sfr_wr && (i_sfr_sel == SEL_C1_LOW);
    assign wr_c1_high  = i_sfr_wr && (i_sfr_sel == SEL_C1_HIGH);
    assign wr_c2_value = i_sfr_wr && (i_sfr_sel == SEL_C2_VALUE);
    assign rd_c0_high  = i_sfr_rd && (i_sfr_sel == SEL_C0_HIGH);
    assign rd_c1_high  = i_sfr_rd && (i_sfr_sel == SEL_C1_HIGH);

    // ==========================================================
    // shared free-running prescaler divider
    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            psc_cnt_reg <= PSC_RESET;
        end else begin
            psc_cnt_reg <= psc_cnt_reg + 1'b1;
        end
    end

    // ==========================================================
    // low byte buffers of the sixteen-bit units
    // one buffer serves both directions, so a high byte read between a
    // low byte write and the matching high byte write corrupts the load
    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            low_buf0_reg <= BYTE_RESET;
        end else if (wr_c0_low) begin
            low_buf0_reg <= i_sfr_wdata;
        end else if (rd_c0_high) begin
            low_buf0_reg <= count_val[0][7:0];
        end
    end

    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            low_buf1_reg <= BYTE_RESET;
        end else if (wr_c1_low) begin
            low_buf1_reg <= i_sfr_wdata;
        end else if (rd_c1_high) begin
            low_buf1_reg <= count_val[1][7:0];
        end
    end

    // ==========================================================
    // preload paths into the units
    // a high byte write carries the buffered low byte with it
    assign load_en[0]    = wr_c0_high;
    assign load_en[1]    = wr_c1_high;
    assign load_en[2]    = wr_c2_value;
    assign load_value[0] = {i_sfr_wdata, low_buf0_reg};
    assign load_value[1] = {i_sfr_wdata, low_buf1_reg};
    assign load_value[2] = {BYTE_RESET, i_sfr_wdata};

    // ==========================================================
    // per unit: control register, prescaler tick, pin, counter
    genvar u;
    generate
        for (u = 0; u < NUM_UNITS; u++) begin : g_unit
            localparam int         UW       = (u == 2) ? NARROW_BITS : WIDE_BITS;
            localparam logic [7:0] CTRL_MSK = (u == 1) ? CTRL_MASK_NPSC
                                                       : CTRL_MASK_PSC;
            localparam logic [2:0] CTRL_SEL = (u == 0) ? SEL_C0_CTRL
                                            : (u == 1) ? SEL_C1_CTRL
                                                       : SEL_C2_CTRL;
            logic [2:0]          psc_sel;
            logic [PSC_BITS-1:0] psc_mask;
            logic [UW-1:0]       unit_count;
            mode_t               unit_mode;

            // control register; a completed measurement drops the run bit,
            // but a software write in the same cycle takes precedence
            always_ff @(posedge i_clock or negedge i_rstn) begin
                if (!i_rstn) begin
                    ctrl_reg[u] <= CTRL_RESET;
                end else if (i_sfr_wr && (i_sfr_sel == CTRL_SEL)) begin
                    ctrl_reg[u] <= i_sfr_wdata & CTRL_MSK;
                end else if (measure_done[u]) begin
                    ctrl_reg[u][RUN_POS] <= 1'b0;
                end
            end

            assign unit_mode = mode_t'(ctrl_reg[u][MODE_HI_POS:MODE_LO_POS]);
            // unit 1 has no prescaler field, so its field reads zero: ratio 1:1
            assign psc_sel   = ctrl_reg[u][PSC_HI_POS:PSC_LO_POS];
            assign psc_mask  = PSC_BITS'((8'h01 << psc_sel) - 8'h01);
            // tick only feeds internal-clock modes; event mode ignores it
            assign unit_tick[u] = ((psc_cnt_reg & psc_mask) == psc_mask);

            pin_sync u_pin_sync (
                .i_clock (i_clock),
                .i_rstn  (i_rstn),
                .i_pin   (i_event_pin[u]),
                .o_level (),
                .o_rise  (pin_rise[u]),
                .o_fall  (pin_fall[u])
            );

            count_unit #(
                .W (UW)
            ) u_count_unit (
                .i_clock        (i_clock),
                .i_rstn         (i_rstn),
                .i_tick         (unit_tick[u]),
                .i_pin_rise     (pin_rise[u]),
                .i_pin_fall     (pin_fall[u]),
                .i_mode         (unit_mode),
                .i_run          (ctrl_reg[u][RUN_POS]),
                .i_edge         (ctrl_reg[u][EDGE_POS]),
                .i_load         (load_en[u]),
                .i_load_value   (load_value[u][UW-1:0]),
                .o_count        (unit_count),
                .o_overflow     (overflow[u]),
                .o_measure_done (measure_done[u])
            );

            assign count_val[u] = WIDE_BITS'(unit_count);
        end
    endgenerate

    // overflow interrupt requests straight from the units' pulse flops
    assign o_overflow_irq = overflow;

    // ==========================================================
    // read data, registered one cycle after the read strobe
    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            rdata_reg <= BYTE_RESET;
        end else if (i_sfr_rd) begin
            case (i_sfr_sel)
                SEL_C0_LOW:   rdata_reg <= low_buf0_reg;
                SEL_C0_HIGH:  rdata_reg <= count_val[0][15:8];
                SEL_C1_LOW:   rdata_reg <= low_buf1_reg;
                SEL_C1_HIGH:  rdata_reg <= count_val[1][15:8];
                SEL_C2_VALUE: rdata_reg <= count_val[2][7:0];
                SEL_C0_CTRL:  rdata_reg <= ctrl_reg[0];
                SEL_C1_CTRL:  rdata_reg <= ctrl_reg[1];
                SEL_C2_CTRL:  rdata_reg <= ctrl_reg[2];
                default:      rdata_reg <= BYTE_RESET;
            endcase
        end
    end

    assign o_sfr_rdata = rdata_reg;
endmodule : timer_event_counter_set
`default_nettype wire

// *** dv/timer_event_props.sv ***
// port-level assertions for the timer/event counter set
`timescale 1ns/100ps
`default_nettype none
module timer_event_props
    import timer_event_pkg::*;
(
    input  wire logic                 i_clock,
    input  wire logic                 i_rstn,
    input  wire logic [2:0]           i_sfr_sel,
    input  wire logic                 i_sfr_wr,
    input  wire logic                 i_sfr_rd,
    input  wire logic [7:0]           i_sfr_wdata,
    input  wire logic [7:0]           o_sfr_rdata,
    input  wire logic [NUM_UNITS-1:0] i_event_pin,
    input  wire logic [NUM_UNITS-1:0] o_overflow_irq
);
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_rstn);

    // ==========================================================
    // run bits as software last wrote them
    // hardware may clear a run bit in pulse mode, never set one
    logic [NUM_UNITS-1:0] run_sw_reg;
    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            run_sw_reg <= '0;
        end else if (i_sfr_wr && i_sfr_sel >= SEL_C0_CTRL) begin
            run_sw_reg[2'(i_sfr_sel - SEL_C0_CTRL)] <= i_sfr_wdata[RUN_POS];
        end
    end

    // ==========================================================
    // bus sequences
    sequence s_wr(logic [2:0] s);
        i_sfr_wr && i_sfr_sel == s;
    endsequence
    sequence s_rd(logic [2:0] s);
        i_sfr_rd && i_sfr_sel == s;
    endsequence
    sequence s_load0;
        s_wr(SEL_C0_LOW) ##1 (i_sfr_wr && i_sfr_sel == SEL_C0_HIGH && !run_sw_reg[0]);
    endsequence

    property p_irq_one_cycle;
        (o_overflow_irq & $past(o_overflow_irq)) == '0;
    endproperty
    property p_irq_needs_run;
        (o_overflow_irq & ~$past(run_sw_reg)) == '0;
    endproperty
    property p_c0_low_buffer;
        s_wr(SEL_C0_LOW) ##1 s_rd(SEL_C0_LOW) |=> o_sfr_rdata == $past(i_sfr_wdata, 2);
    endproperty
    property p_c0_load_high;
        s_load0 ##1 s_rd(SEL_C0_HIGH) |=> o_sfr_rdata == $past(i_sfr_wdata, 2);
    endproperty
    property p_c0_read_pair;
        s_load0 ##1 s_rd(SEL_C0_HIGH) ##1 s_rd(SEL_C0_LOW)
            |=> o_sfr_rdata == $past(i_sfr_wdata, 4);
    endproperty
    property p_c2_stopped_load;
        (i_sfr_wr && i_sfr_sel == SEL_C2_VALUE && !run_sw_reg[2]) ##1 s_rd(SEL_C2_VALUE)
            |=> o_sfr_rdata == $past(i_sfr_wdata, 2);
    endproperty
    property p_c0_ctrl_mask;
        s_wr(SEL_C0_CTRL) ##1 s_rd(SEL_C0_CTRL)
            |=> o_sfr_rdata == ($past(i_sfr_wdata, 2) & CTRL_MASK_PSC);
    endproperty
    property p_c1_ctrl_mask;
        s_wr(SEL_C1_CTRL) ##1 s_rd(SEL_C1_CTRL)
            |=> o_sfr_rdata == ($past(i_sfr_wdata, 2) & CTRL_MASK_NPSC);
    endproperty

    a_irq_one_cycle: assert property (p_irq_one_cycle)
        else $error("overflow irq longer than one cycle");
    a_irq_needs_run: assert property (p_irq_needs_run)
        else $error("overflow irq from a halted unit");
    a_c0_low_buffer: assert property (p_c0_low_buffer)
        else $error("unit0 low buffer not returned");
    a_c0_load_high: assert property (p_c0_load_high)
        else $error("unit0 high byte not loaded");
    a_c0_read_pair: assert property (p_c0_read_pair)
        else $error("unit0 latched low byte wrong");
    a_c2_stopped_load: assert property (p_c2_stopped_load)
        else $error("unit2 stopped load missed count");
    a_c0_ctrl_mask: assert property (p_c0_ctrl_mask)
        else $error("unit0 control readback wrong");
    a_c1_ctrl_mask: assert property (p_c1_ctrl_mask)
        else $error("unit1 control readback wrong");
endmodule : timer_event_props
`default_nettype wire

// *** dv/event_source.sv ***
// external event pin driver standing in for the outside world
`timescale 1ns/100ps
`default_nettype none
module event_source (
    input  wire logic       i_clock,
    output var  logic [2:0] o_pin
);
    // unit1 idles low so a pulse window opens on its rise
    initial o_pin = 3'h5;

    // ==========================================================
    // fall then rise, each level held 8 cycles, well above the filter
    task automatic pulse(input int idx, input int cnt);
        repeat (cnt) begin
            @(posedge i_clock);
            o_pin[idx] <= ~o_pin[idx];
            repeat (8) @(posedge i_clock);
            o_pin[idx] <= ~o_pin[idx];
            repeat (8) @(posedge i_clock);
        end
    endtask : pulse

    task automatic high_for(input int idx, input int cycles);
        @(posedge i_clock);
        o_pin[idx] <= 1'b1;
        repeat (cycles) @(posedge i_clock);
        o_pin[idx] <= 1'b0;
    endtask : high_for
endmodule : event_source
`default_nettype wire

// *** dv/tb.sv ***
// self-checking bench for the timer/event counter set
`timescale 1ns/100ps
`default_nettype none
module tb
    import timer_event_pkg::*;
;
    logic                 i_clock     = 1'b0;
    logic                 i_rstn      = 1'b0;
    logic [2:0]           i_sfr_sel   = 3'h0;
    logic                 i_sfr_wr    = 1'b0;
    logic                 i_sfr_rd    = 1'b0;
    logic [7:0]           i_sfr_wdata = 8'h00;
    logic [7:0]           o_sfr_rdata;
    logic [NUM_UNITS-1:0] event_pin;
    logic [NUM_UNITS-1:0] o_overflow_irq;
    logic [7:0]           v;
    logic [7:0]           h;
    logic [15:0]          x16;
    int                   n;
    int                   n_mismatch = 0;
    int                   n_checks = 0;

    always #4 i_clock = ~i_clock;

    timer_event_counter_set dut_u (
        .i_clock(i_clock), .i_rstn(i_rstn), .i_sfr_sel(i_sfr_sel),
        .i_sfr_wr(i_sfr_wr), .i_sfr_rd(i_sfr_rd), .i_sfr_wdata(i_sfr_wdata),
        .o_sfr_rdata(o_sfr_rdata), .i_event_pin(event_pin),
        .o_overflow_irq(o_overflow_irq)
    );
    event_source pins_u (.i_clock(i_clock), .o_pin(event_pin));

    // ==========================================================
    // bus helpers; v after each op holds the data of the previous read
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic op(input logic w, input logic r, input logic [2:0] s, input logic [7:0] d);
        @(posedge i_clock);
        i_sfr_wr <= w;
        i_sfr_rd <= r;
        i_sfr_sel <= s;
        i_sfr_wdata <= d;
        @(negedge i_clock);
        v = o_sfr_rdata;
    endtask : op
    task automatic wr(input logic [2:0] s, input logic [7:0] d);
        op(1'b1, 1'b0, s, d);
        op(1'b0, 1'b0, 3'h0, 8'h00);
    endtask : wr
    task automatic rd(input logic [2:0] s);
        op(1'b0, 1'b1, s, 8'h00);
        op(1'b0, 1'b0, 3'h0, 8'h00);
    endtask : rd
    // high location first so the low byte is latched coherently
    task automatic rd16(input logic [2:0] s, output logic [15:0] r);
        op(1'b0, 1'b1, s, 8'h00);
        op(1'b0, 1'b1, s - 3'h1, 8'h00);
        h = v;
        op(1'b0, 1'b0, 3'h0, 8'h00);
        r = {h, v};
    endtask : rd16
    task automatic wait_irq(input int b, output int k);
        k = 0;
        do begin
            @(negedge i_clock);
            k++;
        end while (o_overflow_irq[b] !== 1'b1 && k < 3000);
        if (k >= 3000) chk("irq wait", 16'h0001, 16'h0000);
    endtask : wait_irq

    // ==========================================================
    // scenarios
    task automatic t_reset;
        for (int s = 5; s < 8; s++) begin
            rd(3'(s));
            chk("control reset", {8'h00, CTRL_RESET}, {8'h00, v});
        end
        rd(SEL_C2_VALUE);
        chk("unit2 reset count", 16'h0000, {8'h00, v});
        $display("test reset done");
    endtask : t_reset
    task automatic t_load;
        op(1'b1, 1'b0, SEL_C0_LOW, 8'h34);
        op(1'b1, 1'b0, SEL_C0_HIGH, 8'h12);
        op(1'b0, 1'b1, SEL_C0_HIGH, 8'h00);
        op(1'b0, 1'b1, SEL_C0_LOW, 8'h00);
        chk("unit0 high", 16'h0012, {8'h00, v});
        op(1'b1, 1'b0, SEL_C0_LOW, 8'h56);
        chk("unit0 low", 16'h0034, {8'h00, v});
        op(1'b0, 1'b1, SEL_C0_LOW, 8'h00);
        op(1'b0, 1'b0, 3'h0, 8'h00);
        chk("unit0 buffer", 16'h0056, {8'h00, v});
        rd16(SEL_C0_HIGH, x16);
        chk("unit0 count", 16'h1234, x16);
        $display("test load done");
    endtask : t_load
    task automatic t_ctrl;
        op(1'b1, 1'b0, SEL_C1_CTRL, 8'hbf);
        op(1'b0, 1'b1, SEL_C1_CTRL, 8'h00);
        op(1'b1, 1'b0, SEL_C0_CTRL, 8'h2f);
        chk("unit1 control", 16'h0098, {8'h00, v});
        op(1'b0, 1'b1, SEL_C0_CTRL, 8'h00);
        op(1'b1, 1'b0, SEL_C1_CTRL, 8'h00);
        chk("unit0 control", 16'h000f, {8'h00, v});
        op(1'b0, 1'b0, 3'h0, 8'h00);
        $display("test control done");
    endtask : t_ctrl
    task automatic t_timer;
        op(1'b1, 1'b0, SEL_C2_VALUE, 8'hf0);
        op(1'b0, 1'b1, SEL_C2_VALUE, 8'h00);
        op(1'b0, 1'b0, 3'h0, 8'h00);
        chk("unit2 stopped load", 16'h00f0, {8'h00, v});
        wr(SEL_C2_CTRL, 8'h90);
        wait_irq(2, n);
        wait_irq(2, n);
        chk("unit2 period", 16'h0010, 16'(n));
        wr(SEL_C2_VALUE, 8'h80);
        rd(SEL_C2_VALUE);
        chk("unit2 running count", 16'h000f, {12'h000, v[7:4]});
        wait_irq(2, n);
        wait_irq(2, n);
        chk("unit2 reload period", 16'h0080, 16'(n));
        wr(SEL_C2_CTRL, 8'h91);
        wait_irq(2, n);
        wait_irq(2, n);
        chk("unit2 divided period", 16'h0100, 16'(n));
        wr(SEL_C2_CTRL, 8'h00);
        $display("test timer done");
    endtask : t_timer
    task automatic t_event;
        op(1'b1, 1'b0, SEL_C0_LOW, 8'hfd);
        wr(SEL_C0_HIGH, 8'hff);
        wr(SEL_C0_CTRL, 8'h5f);
        pins_u.pulse(0, 2);
        rd16(SEL_C0_HIGH, x16);
        chk("unit0 two falls", 16'hffff, x16);
        fork
            pins_u.pulse(0, 1);
            wait_irq(0, n);
        join
        chk("unit0 event overflow", 16'h0001, {15'h0000, n < 12});
        wr(SEL_C0_CTRL, 8'h50);
        pins_u.pulse(0, 1);
        rd16(SEL_C0_HIGH, x16);
        chk("unit0 one rise", 16'hfffe, x16);
        wr(SEL_C0_CTRL, 8'h00);
        $display("test event done");
    endtask : t_event
    task automatic t_pulse;
        op(1'b1, 1'b0, SEL_C1_LOW, 8'h00);
        wr(SEL_C1_HIGH, 8'h00);
        wr(SEL_C1_CTRL, 8'hd8);
        pins_u.high_for(1, 40);
        repeat (10) @(posedge i_clock);
        rd16(SEL_C1_HIGH, x16);
        chk("unit1 pulse width", 16'h0028, x16);
        rd(SEL_C1_CTRL);
        chk("unit1 run cleared", 16'h00c8, {8'h00, v});
        $display("test pulse done");
    endtask : t_pulse

    task automatic finish_test;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : finish_test

    initial begin
        repeat (16) @(posedge i_clock);
        i_rstn <= 1'b1;
        t_reset();
        t_load();
        t_ctrl();
        t_timer();
        t_event();
        t_pulse();
        finish_test();
    end
    // the whole run needs under a thousand cycles
    initial begin
        #200000;
        n_mismatch++;
        finish_test();
    end
endmodule : tb

bind timer_event_counter_set timer_event_props props_u (
    .i_clock(i_clock), .i_rstn(i_rstn), .i_sfr_sel(i_sfr_sel),
    .i_sfr_wr(i_sfr_wr), .i_sfr_rd(i_sfr_rd), .i_sfr_wdata(i_sfr_wdata),
    .o_sfr_rdata(o_sfr_rdata), .i_event_pin(i_event_pin),
    .o_overflow_irq(o_overflow_irq)
);
`default_nettype wire
